// file: fls_pkg.sv
// Shared constants, opcodes and command layout for the flag/transfer unit
package fls_pkg;

	// Avalon slave geometry
	localparam int ADDR_W = 11;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [10:0] OFF_CMD = 11'h000;
	localparam logic [10:0] OFF_KADDR = 11'h004;
	localparam logic [10:0] OFF_FLAGS = 11'h008;
	localparam logic [10:0] OFF_STAT = 11'h00c;
	localparam logic [10:0] OFF_RF = 11'h080;
	localparam logic [10:0] OFF_MEM = 11'h400;

	// Reset values
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [15:0] KADDR_RST = 16'h0000;

	// Bit positions inside the flag register
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_S = 4;
	localparam int FL_H = 5;
	localparam int FL_T = 6;
	localparam int FL_I = 7;

	// Low register of each pointer pair
	localparam logic [4:0] PTR_X_LO = 5'h1a;
	localparam logic [4:0] PTR_Y_LO = 5'h1c;
	localparam logic [4:0] PTR_Z_LO = 5'h1e;

	// Pointer selectors
	localparam logic [1:0] PSEL_X = 2'h0;
	localparam logic [1:0] PSEL_Y = 2'h1;

	// Indirect addressing modes
	localparam logic [1:0] MODE_PLAIN = 2'h0;
	localparam logic [1:0] MODE_POST = 2'h1;
	localparam logic [1:0] MODE_PRE = 2'h2;

	// Operation codes
	typedef enum logic [3:0] {
		OP_ROR = 4'h0,
		OP_BST = 4'h1,
		OP_BLD = 4'h2,
		OP_SES = 4'h3,
		OP_CLS = 4'h4,
		OP_SEV = 4'h5,
		OP_CLV = 4'h6,
		OP_SEH = 4'h7,
		OP_CLH = 4'h8,
		OP_LD = 4'h9,
		OP_LDD = 4'ha,
		OP_LDS = 4'hb,
		OP_ST = 4'hc,
		OP_STD = 4'hd,
		OP_STS = 4'he
	} fls_op_t;

	// Command word as written to the command register, top bits first
	typedef struct packed {
		logic [5:0] disp;
		logic [1:0] psel;
		logic [1:0] mode;
		logic [2:0] bitsel;
		logic [4:0] regn;
		fls_op_t op;
	} fls_cmd_t;

	localparam int CMD_W = 22;

	// Controller states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_EXEC = 3'h2,
		ST_MEM = 3'h4
	} fls_state_t;

endpackage : fls_pkg

// file: fls_exec_unit.sv
// Flag, bit-transfer and load/store execution unit with Avalon-MM slave
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Rotate through carry: C to bit 7, bit 0 to C, Z C N V updated.
// - Bit store copies the chosen bit into the transfer flag only.
// - Bit load writes the transfer flag into one register bit only.
// - Signed-test flag set/clear: one cycle, no other flag touched.
// - Overflow flag set/clear: one cycle, no other flag touched.
// - Half-carry flag set/clear: one cycle, no other flag touched.
// - Post-increment load reads at the pointer, then bumps it, 2 cycles.
// - Pre-decrement load lowers the pointer, then reads there, 2 cycles.
// - Displaced load reads pointer plus offset, pointer kept, 2 cycles.
// - Direct load reads at the address constant in 2 cycles, flags kept.
// - Post-increment store writes at the pointer, then bumps it, 2 cycles.
// - Pre-decrement store lowers the pointer, then writes there, 2 cycles.
// - Displaced store writes pointer plus offset, pointer kept, 2 cycles.
// - Direct store writes at the address constant, 2 cycles, flags kept.
module fls_exec_unit #(
	parameter int MEM_DEPTH = 128
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [10:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out
);
	localparam int MAW = $clog2(MEM_DEPTH);
	// Memory window is 256 words wide and indexed by low address bits
	generate
		if (MEM_DEPTH < 2 || MEM_DEPTH > 256 ||
			(MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : g_bad
			$error("MEM_DEPTH must be a power of two from 2 to 256");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// State and storage
	fls_pkg::fls_state_t state_reg, state_next;
	fls_pkg::fls_cmd_t cmd_reg, cmd_next;
	logic [15:0] kaddr_reg, kaddr_next;
	logic [15:0] ea_reg, ea_next;
	logic [7:0] flag_reg, flag_next;
	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0] rf [0:31];
	logic [7:0] mem [0:MEM_DEPTH-1];

	logic rf_we;
	logic [4:0] rf_wa;
	logic [7:0] rf_wd;
	logic ptr_we;
	logic [15:0] ptr_wd;
	logic mem_we;
	logic [MAW-1:0] mem_wa;
	logic [7:0] mem_wd;

	////////////////////////////////////////////////////////////////////
	// Operand and pointer views
	logic [31:0] wdata_m;
	logic [4:0] plo;
	logic [15:0] ptr_val;
	logic [7:0] opnd;
	logic [7:0] mem_rd;
	logic [7:0] ror_res;
	logic bus_req;

	// Byte lanes not enabled read as zero into the registers
	generate
		for (genvar b = 0; b < 4; b++) begin : g_lane
			assign wdata_m[8*b +: 8] = avs_byteenable_in[b] ?
				avs_writedata_in[8*b +: 8] : 8'h00;
		end
	endgenerate

	// Pointer pair select; the unused code falls back to the last pair
	always_comb begin
		unique case (cmd_reg.psel)
			fls_pkg::PSEL_X: plo = fls_pkg::PTR_X_LO;
			fls_pkg::PSEL_Y: plo = fls_pkg::PTR_Y_LO;
			default: plo = fls_pkg::PTR_Z_LO;
		endcase
	end

	assign ptr_val = {rf[{plo[4:1], 1'b1}], rf[plo]};
	assign opnd = rf[cmd_reg.regn];
	assign mem_rd = mem[ea_reg[MAW-1:0]];
	assign ror_res = {flag_reg[fls_pkg::FL_C], opnd[7:1]};
	assign bus_req = (avs_read_in || avs_write_in) && wait_reg &&
		state_reg == fls_pkg::ST_IDLE;

	////////////////////////////////////////////////////////////////////
	// Bus decode, command start and execution sequencing
	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		kaddr_next = kaddr_reg;
		ea_next = ea_reg;
		flag_next = flag_reg;
		wait_next = 1'b1;
		rdata_next = rdata_reg;
		rf_we = 1'b0;
		rf_wa = cmd_reg.regn;
		rf_wd = opnd;
		ptr_we = 1'b0;
		ptr_wd = ptr_val;
		mem_we = 1'b0;
		mem_wa = ea_reg[MAW-1:0];
		mem_wd = opnd;
		unique case (state_reg)
			fls_pkg::ST_IDLE: begin
				// Accesses are only taken while idle, so bus writes never
				// race an instruction for the register file
				if (bus_req) begin
					wait_next = 1'b0;
					rdata_next = 32'h0000_0000;
					if (avs_address_in == fls_pkg::OFF_CMD) begin
						rdata_next = {10'h000, cmd_reg};
						if (avs_write_in) begin
							cmd_next = fls_pkg::fls_cmd_t'(
								wdata_m[fls_pkg::CMD_W-1:0]);
							state_next = fls_pkg::ST_EXEC;
						end
					end else if (avs_address_in == fls_pkg::OFF_KADDR) begin
						rdata_next = {16'h0000, kaddr_reg};
						if (avs_write_in)
							kaddr_next = wdata_m[15:0];
					end else if (avs_address_in == fls_pkg::OFF_FLAGS) begin
						rdata_next = {24'h000000, flag_reg};
						if (avs_write_in)
							flag_next = wdata_m[7:0];
					end else if (avs_address_in == fls_pkg::OFF_STAT) begin
						rdata_next = {16'h0000, ea_reg};
					end else if (avs_address_in[10:7] ==
						fls_pkg::OFF_RF[10:7] && avs_address_in[1:0] == 2'h0) begin
						rdata_next = {24'h000000, rf[avs_address_in[6:2]]};
						if (avs_write_in) begin
							rf_we = 1'b1;
							rf_wa = avs_address_in[6:2];
							rf_wd = wdata_m[7:0];
						end
					end else if (avs_address_in[10] == fls_pkg::OFF_MEM[10] &&
						avs_address_in[1:0] == 2'h0 &&
						int'(avs_address_in[9:2]) < MEM_DEPTH) begin
						rdata_next = {24'h000000,
							mem[avs_address_in[MAW+1:2]]};
						if (avs_write_in) begin
							mem_we = 1'b1;
							mem_wa = avs_address_in[MAW+1:2];
							mem_wd = wdata_m[7:0];
						end
					end
				end
			end
			fls_pkg::ST_EXEC: begin
				state_next = fls_pkg::ST_IDLE;
				unique case (cmd_reg.op)
					fls_pkg::OP_ROR: begin
						rf_we = 1'b1;
						rf_wd = ror_res;
						flag_next[fls_pkg::FL_C] = opnd[0];
						flag_next[fls_pkg::FL_N] = ror_res[7];
						flag_next[fls_pkg::FL_Z] = ror_res == 8'h00;
						flag_next[fls_pkg::FL_V] = ror_res[7] ^ opnd[0];
					end
					fls_pkg::OP_BST:
						flag_next[fls_pkg::FL_T] = opnd[cmd_reg.bitsel];
					fls_pkg::OP_BLD: begin
						rf_we = 1'b1;
						rf_wd[cmd_reg.bitsel] = flag_reg[fls_pkg::FL_T];
					end
					fls_pkg::OP_SES: flag_next[fls_pkg::FL_S] = 1'b1;
					fls_pkg::OP_CLS: flag_next[fls_pkg::FL_S] = 1'b0;
					fls_pkg::OP_SEV: flag_next[fls_pkg::FL_V] = 1'b1;
					fls_pkg::OP_CLV: flag_next[fls_pkg::FL_V] = 1'b0;
					fls_pkg::OP_SEH: flag_next[fls_pkg::FL_H] = 1'b1;
					fls_pkg::OP_CLH: flag_next[fls_pkg::FL_H] = 1'b0;
					fls_pkg::OP_LD, fls_pkg::OP_ST: begin
						// First cycle forms the address; pre-decrement
						// writes the pointer back right away
						state_next = fls_pkg::ST_MEM;
						ea_next = ptr_val;
						if (cmd_reg.mode == fls_pkg::MODE_PRE) begin
							ptr_we = 1'b1;
							ptr_wd = ptr_val - 16'h0001;
							ea_next = ptr_wd;
						end
					end
					fls_pkg::OP_LDD, fls_pkg::OP_STD: begin
						state_next = fls_pkg::ST_MEM;
						ea_next = ptr_val + {10'h000, cmd_reg.disp};
					end
					fls_pkg::OP_LDS, fls_pkg::OP_STS: begin
						state_next = fls_pkg::ST_MEM;
						ea_next = kaddr_reg;
					end
					default: state_next = fls_pkg::ST_IDLE;
				endcase
			end
			fls_pkg::ST_MEM: begin
				state_next = fls_pkg::ST_IDLE;
				// Address wraps to the memory depth on the low bits
				if (cmd_reg.op == fls_pkg::OP_ST || cmd_reg.op == fls_pkg::OP_STD ||
					cmd_reg.op == fls_pkg::OP_STS) begin
					mem_we = 1'b1;
				end else begin
					rf_we = 1'b1;
					rf_wd = mem_rd;
				end
				if ((cmd_reg.op == fls_pkg::OP_LD || cmd_reg.op == fls_pkg::OP_ST) &&
					cmd_reg.mode == fls_pkg::MODE_POST) begin
					ptr_we = 1'b1;
					ptr_wd = ptr_val + 16'h0001;
				end
			end
			default: state_next = fls_pkg::ST_IDLE;
		endcase
	end

	// Control registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= fls_pkg::ST_IDLE;
			cmd_reg <= '0;
			kaddr_reg <= fls_pkg::KADDR_RST;
			ea_reg <= 16'h0000;
			flag_reg <= fls_pkg::FLAGS_RST;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			kaddr_reg <= kaddr_next;
			ea_reg <= ea_next;
			flag_reg <= flag_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// Register file; a load into a pointer byte overrides the step
	always_ff @(posedge clk_in) begin
		if (ptr_we) begin
			rf[plo] <= ptr_wd[7:0];
			rf[{plo[4:1], 1'b1}] <= ptr_wd[15:8];
		end
		if (rf_we)
			rf[rf_wa] <= rf_wd;
	end

	// Data memory, no reset: contents are software's business
	always_ff @(posedge clk_in) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	assign avs_readdata_out = rdata_reg;
	assign avs_waitrequest_out = wait_reg;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	logic in_exec;
	logic is_mem_op;
	assign in_exec = state_reg == fls_pkg::ST_EXEC;
	assign is_mem_op = cmd_reg.op >= fls_pkg::OP_LD &&
		cmd_reg.op <= fls_pkg::OP_STS;

	a_ror_rotate: assert property (
		in_exec && cmd_reg.op == fls_pkg::OP_ROR |=>
		rf[cmd_reg.regn] == {$past(flag_reg[fls_pkg::FL_C]), $past(opnd[7:1])}
		&& flag_reg[fls_pkg::FL_C] == $past(opnd[0])
		&& state_reg == fls_pkg::ST_IDLE)
		else $error("rotate result or carry wrong");

	a_bst_flag: assert property (
		in_exec && cmd_reg.op == fls_pkg::OP_BST |=>
		flag_reg == {$past(flag_reg[7]), $past(opnd[cmd_reg.bitsel]),
		$past(flag_reg[5:0])})
		else $error("bit store flag wrong");

	a_bld_bit: assert property (
		in_exec && cmd_reg.op == fls_pkg::OP_BLD |=>
		rf[cmd_reg.regn][cmd_reg.bitsel] == $past(flag_reg[fls_pkg::FL_T])
		&& $stable(flag_reg))
		else $error("bit load wrong");

	a_sign_ops: assert property (
		in_exec && (cmd_reg.op == fls_pkg::OP_SES ||
		cmd_reg.op == fls_pkg::OP_CLS) |=>
		flag_reg == ($past(flag_reg) & 8'hef |
		{3'h0, $past(cmd_reg.op) == fls_pkg::OP_SES, 4'h0}))
		else $error("signed flag op wrong");
	a_ovf_ops: assert property (
		in_exec && cmd_reg.op inside {fls_pkg::OP_SEV, fls_pkg::OP_CLV} |=>
		flag_reg == ($past(flag_reg) & 8'hf7 |
		{4'h0, $past(cmd_reg.op) == fls_pkg::OP_SEV, 3'h0}))
		else $error("overflow flag op wrong");
	a_half_ops: assert property (
		in_exec && cmd_reg.op inside {fls_pkg::OP_SEH, fls_pkg::OP_CLH} |=>
		flag_reg == ($past(flag_reg) & 8'hdf |
		{2'h0, $past(cmd_reg.op) == fls_pkg::OP_SEH, 5'h00}))
		else $error("half carry flag op wrong");
	a_mem_twocyc: assert property (
		in_exec && is_mem_op |=> state_reg == fls_pkg::ST_MEM
		##1 state_reg == fls_pkg::ST_IDLE && $stable(flag_reg))
		else $error("memory op not two cycles");

	a_post_step: assert property (
		in_exec && cmd_reg.op == fls_pkg::OP_LD &&
		cmd_reg.mode == fls_pkg::MODE_POST && cmd_reg.regn[4:1] != plo[4:1]
		|-> ##2 ptr_val == $past(ptr_val, 2) + 16'h0001)
		else $error("post increment wrong");

	a_pre_step: assert property (
		in_exec && cmd_reg.op == fls_pkg::OP_ST &&
		cmd_reg.mode == fls_pkg::MODE_PRE |=>
		ptr_val == $past(ptr_val) - 16'h0001 && ea_reg == ptr_val)
		else $error("pre decrement wrong");
	a_disp_keep: assert property (
		in_exec && cmd_reg.op == fls_pkg::OP_STD |-> ##2
		ptr_val == $past(ptr_val, 2) &&
		mem[$past(ea_reg[MAW-1:0])] == $past(opnd))
		else $error("displaced store wrong");
	a_load_data: assert property (
		state_reg == fls_pkg::ST_MEM && cmd_reg.op == fls_pkg::OP_LDD |=>
		rf[cmd_reg.regn] == $past(mem_rd))
		else $error("displaced load data wrong");

	c_ror: cover property (in_exec && cmd_reg.op == fls_pkg::OP_ROR);
	c_post_load: cover property (in_exec && cmd_reg.op == fls_pkg::OP_LD &&
		cmd_reg.mode == fls_pkg::MODE_POST);
	c_pre_store: cover property (in_exec && cmd_reg.op == fls_pkg::OP_ST &&
		cmd_reg.mode == fls_pkg::MODE_PRE);
	c_bus_write: cover property (!wait_reg && avs_write_in);

endmodule : fls_exec_unit

// file: fls_exec_unit_test.sv
// Self-checking bench for the flag, bit-transfer and load/store unit
`timescale 1ns/1ps
module fls_exec_unit_test;

	localparam int MEM_DEPTH = 128;
	// Whole run needs well under a thousand cycles; this leaves a wide margin
	localparam int LIMIT = 20000;

	logic clk_in;
	logic rst_n_in;
	logic [10:0] avs_address_in;
	logic avs_read_in;
	logic avs_write_in;
	logic [3:0] avs_byteenable_in;
	logic [31:0] avs_writedata_in;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	int miscompares;
	int checks;
	int cycles;
	logic [31:0] rd;
	logic [7:0] m;
	logic [7:0] init;
	fls_pkg::fls_op_t fops [6] = '{fls_pkg::OP_SES, fls_pkg::OP_CLS,
		fls_pkg::OP_SEV, fls_pkg::OP_CLV, fls_pkg::OP_SEH, fls_pkg::OP_CLH};
	int fbit [6] = '{fls_pkg::FL_S, fls_pkg::FL_S, fls_pkg::FL_V,
		fls_pkg::FL_V, fls_pkg::FL_H, fls_pkg::FL_H};

	fls_exec_unit #(
		.MEM_DEPTH(MEM_DEPTH)
	) u_dut (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in),
		.avs_byteenable_in(avs_byteenable_in),
		.avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #20 clk_in = ~clk_in;

	// A stuck waitrequest would hang the bus tasks, so cut it here
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			$display("[FAIL] %0t run did not finish in time", $time);
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Verdict and comparison
	task stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	////////////////////////////////////////////////////////////////////////
	// Avalon master: hold the request until waitrequest is sampled low
	task bus(input logic wr, input logic [10:0] a, input logic [31:0] d);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		// One idle edge so strobes are never driven twice in one step
		@(posedge clk_in);
	endtask : bus

	task wreg(input logic [4:0] n, input logic [7:0] v);
		bus(1'b1, fls_pkg::OFF_RF + {4'h0, n, 2'b00}, {24'h0, v});
	endtask : wreg

	task creg(input logic [4:0] n, input logic [7:0] exp);
		bus(1'b0, fls_pkg::OFF_RF + {4'h0, n, 2'b00}, 32'h0);
		check(rd, {24'h0, exp});
	endtask : creg

	task wmem(input logic [6:0] i, input logic [7:0] v);
		bus(1'b1, fls_pkg::OFF_MEM + {2'h0, i, 2'b00}, {24'h0, v});
	endtask : wmem

	task cmem(input logic [6:0] i, input logic [7:0] exp);
		bus(1'b0, fls_pkg::OFF_MEM + {2'h0, i, 2'b00}, 32'h0);
		check(rd, {24'h0, exp});
	endtask : cmem

	task wflags(input logic [7:0] v);
		bus(1'b1, fls_pkg::OFF_FLAGS, {24'h0, v});
	endtask : wflags

	task cflags(input logic [7:0] exp);
		bus(1'b0, fls_pkg::OFF_FLAGS, 32'h0);
		check(rd, {24'h0, exp});
	endtask : cflags

	// Issue one instruction; later accesses stall until it has finished
	task cmd(input fls_pkg::fls_op_t op, input logic [4:0] n,
		input logic [2:0] b, input logic [1:0] md, input logic [1:0] ps,
		input logic [5:0] q);
		fls_pkg::fls_cmd_t c;
		c = '{disp: q, psel: ps, mode: md, bitsel: b, regn: n, op: op};
		bus(1'b1, fls_pkg::OFF_CMD, {10'h0, c});
	endtask : cmd

	// One memory transfer through register 7, pointer start p0, end p1
	task mem_case(input fls_pkg::fls_op_t op, input logic [1:0] md,
		input logic [1:0] ps, input logic [5:0] q, input logic [15:0] p0,
		input logic [15:0] p1, input logic [15:0] ea, input logic [7:0] v);
		logic [4:0] lo;
		logic st;
		lo = 5'h1a + {ps, 1'b0};
		st = (op >= fls_pkg::OP_ST);
		// Target starts with the inverse so a missed transfer shows
		if (st) begin
			wreg(5'h07, v);
			wmem(ea[6:0], ~v);
		end else begin
			wmem(ea[6:0], v);
			wreg(5'h07, ~v);
		end
		wreg(lo, p0[7:0]);
		wreg(lo + 5'h01, p0[15:8]);
		bus(1'b1, fls_pkg::OFF_KADDR, {16'h0, ea});
		wflags(8'h2b);
		cmd(op, 5'h07, 3'h0, md, ps, q);
		if (st)
			cmem(ea[6:0], v);
		else
			creg(5'h07, v);
		creg(lo, p1[7:0]);
		creg(lo + 5'h01, p1[15:8]);
		cflags(8'h2b);
		bus(1'b0, fls_pkg::OFF_STAT, 32'h0);
		check(rd, {16'h0, ea});
	endtask : mem_case

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk_in = 1'b0;
		rst_n_in = 1'b0;
		avs_address_in = 11'h000;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_byteenable_in = 4'hf;
		avs_writedata_in = 32'h0;
		miscompares = 0;
		checks = 0;
		cycles = 0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);

		// Reset values and an unmapped read
		cflags(fls_pkg::FLAGS_RST);
		bus(1'b0, fls_pkg::OFF_KADDR, 32'h0);
		check(rd, {16'h0, fls_pkg::KADDR_RST});
		bus(1'b0, 11'h7fc, 32'h0);
		check(rd, 32'h0);
		$display("test reset done");

		// Each flag op flips only its own bit against a busy pattern
		for (int i = 0; i < 6; i++) begin
			m = 8'h01 << fbit[i];
			init = (i % 2 == 0) ? (8'ha5 & ~m) : (8'ha5 | m);
			wflags(init);
			cmd(fops[i], 5'h00, 3'h0, 2'h0, 2'h0, 6'h00);
			cflags(init ^ m);
		end
		$display("test flag set clear done");

		// Rotate: carry in on top, bit 0 out to carry, S kept
		wflags(8'h19);
		wreg(5'h05, 8'h81);
		cmd(fls_pkg::OP_ROR, 5'h05, 3'h0, 2'h0, 2'h0, 6'h00);
		creg(5'h05, 8'hc0);
		cflags(8'h15);
		wflags(8'h00);
		wreg(5'h05, 8'h01);
		cmd(fls_pkg::OP_ROR, 5'h05, 3'h0, 2'h0, 2'h0, 6'h00);
		creg(5'h05, 8'h00);
		cflags(8'h0b);
		$display("test rotate done");

		// Bit copy in both directions, one and zero
		wflags(8'h00);
		wreg(5'h03, 8'h20);
		cmd(fls_pkg::OP_BST, 5'h03, 3'h5, 2'h0, 2'h0, 6'h00);
		cflags(8'h40);
		creg(5'h03, 8'h20);
		wflags(8'hff);
		cmd(fls_pkg::OP_BST, 5'h03, 3'h4, 2'h0, 2'h0, 6'h00);
		cflags(8'hbf);
		wflags(8'h40);
		wreg(5'h04, 8'h00);
		cmd(fls_pkg::OP_BLD, 5'h04, 3'h7, 2'h0, 2'h0, 6'h00);
		creg(5'h04, 8'h80);
		cflags(8'h40);
		wflags(8'hbf);
		wreg(5'h04, 8'hff);
		cmd(fls_pkg::OP_BLD, 5'h04, 3'h0, 2'h0, 2'h0, 6'h00);
		creg(5'h04, 8'hfe);
		cflags(8'hbf);
		$display("test bit copy done");

		// Loads, including pointer wrap at both ends of the range
		mem_case(fls_pkg::OP_LD, fls_pkg::MODE_POST, fls_pkg::PSEL_X, 6'h00,
			16'h0010, 16'h0011, 16'h0010, 8'h5a);
		mem_case(fls_pkg::OP_LD, fls_pkg::MODE_PRE, fls_pkg::PSEL_Y, 6'h00,
			16'h0010, 16'h000f, 16'h000f, 8'h3c);
		mem_case(fls_pkg::OP_LD, fls_pkg::MODE_PRE, fls_pkg::PSEL_X, 6'h00,
			16'h0000, 16'hffff, 16'hffff, 8'h77);
		mem_case(fls_pkg::OP_LD, fls_pkg::MODE_POST, 2'h2, 6'h00,
			16'hffff, 16'h0000, 16'hffff, 8'h66);
		mem_case(fls_pkg::OP_LDD, fls_pkg::MODE_PLAIN, fls_pkg::PSEL_Y, 6'h3f,
			16'h0020, 16'h0020, 16'h005f, 8'h99);
		mem_case(fls_pkg::OP_LDS, fls_pkg::MODE_PLAIN, fls_pkg::PSEL_X, 6'h00,
			16'h1234, 16'h1234, 16'h0030, 8'hab);
		mem_case(fls_pkg::OP_LD, fls_pkg::MODE_PLAIN, fls_pkg::PSEL_X, 6'h00,
			16'h0021, 16'h0021, 16'h0021, 8'h24);
		$display("test loads done");

		// Stores, including a carry into the pointer's high byte
		mem_case(fls_pkg::OP_ST, fls_pkg::MODE_POST, 2'h2, 6'h00,
			16'h0040, 16'h0041, 16'h0040, 8'hc3);
		mem_case(fls_pkg::OP_ST, fls_pkg::MODE_PRE, fls_pkg::PSEL_Y, 6'h00,
			16'h0045, 16'h0044, 16'h0044, 8'h1e);
		mem_case(fls_pkg::OP_ST, fls_pkg::MODE_POST, fls_pkg::PSEL_X, 6'h00,
			16'h00ff, 16'h0100, 16'h00ff, 8'h81);
		mem_case(fls_pkg::OP_STD, fls_pkg::MODE_PLAIN, 2'h2, 6'h05,
			16'h0041, 16'h0041, 16'h0046, 8'he7);
		mem_case(fls_pkg::OP_STS, fls_pkg::MODE_PLAIN, fls_pkg::PSEL_Y, 6'h00,
			16'h0200, 16'h0200, 16'h0050, 8'h42);
		mem_case(fls_pkg::OP_ST, fls_pkg::MODE_PLAIN, fls_pkg::PSEL_Y, 6'h00,
			16'h0022, 16'h0022, 16'h0022, 8'h18);
		$display("test stores done");

		stop_test();
	end

endmodule : fls_exec_unit_test
